// ==== src/cafm_params.svh ====
// Register indices, field positions and reset values of the acceptance filter block
`ifndef CAFM_PARAMS_SVH
`define CAFM_PARAMS_SVH

// Register indices; byte address is four times the index
`define CAFM_IDX_CTRL 6'h00
`define CAFM_IDX_INITACK 6'h01
`define CAFM_IDX_MODE 6'h02
`define CAFM_IDX_STAT 6'h03
`define CAFM_IDX_IRQMASK 6'h04
`define CAFM_IDX_HIT 6'h05
`define CAFM_IDX_TXGO 6'h06
`define CAFM_IDX_CODE1 6'h10
`define CAFM_IDX_IGN1 6'h14
`define CAFM_IDX_CODE2 6'h18
`define CAFM_IDX_IGN2 6'h1C
`define CAFM_IDX_IGN2_LAST 6'h1F
`define CAFM_IDX_RXBUF 6'h20
`define CAFM_IDX_TXBUF 6'h30

// Message buffer layout
`define CAFM_BUF_BYTES 16
`define CAFM_BUF_USED 13
`define CAFM_BUF_DLC 12
`define CAFM_BUF_PRIO 13
`define CAFM_BUF_TS_HI 14
`define CAFM_BUF_TS_LO 15

// Field positions
`define CAFM_CTRL_INIT_REQUEST 0
`define CAFM_CTRL_TIME 1
`define CAFM_STAT_RXF 0
`define CAFM_STAT_TXD 1
`define CAFM_STAT_OVR 2
`define CAFM_TXGO_BIT 0

// Reset values
`define CAFM_RST_CTRL 2'h0
`define CAFM_RST_BYTE 8'h00
`define CAFM_RST_STAT 3'h0
`define CAFM_RST_HIT 3'h0
`define CAFM_RST_TIMER 16'h0000

`endif

// ==== src/cafm_pkg.sv ====
// Types shared by the acceptance filter block
package cafm_pkg;
  typedef enum logic [1:0] {
    CAFM_MODE_32,
    CAFM_MODE_16,
    CAFM_MODE_8,
    CAFM_MODE_CLOSED
  } cafm_mode_t;
endpackage : cafm_pkg

// ==== src/cafm_bank_match.sv ====
// One filter bank: four code bytes and four ignore bytes against an identifier
`timescale 1ns/1ps
`default_nettype none
module cafm_bank_match (
  // Bank contents, byte 0 in bits 31:24
  input wire logic [31:0] code,
  input wire logic [31:0] ign,
  // Received identifier bytes, byte 0 in bits 31:24
  input wire logic [31:0] id,
  input wire cafm_pkg::cafm_mode_t mode,
  // Hits in bank order
  output logic [3:0] hits
);
  // Set ignore bits drop out, clear ones must agree
  function automatic logic agree(input logic [15:0] a, input logic [15:0] c,
                                 input logic [15:0] m);
    agree = ~|((a ^ c) & ~m);
  endfunction : agree

  always_comb
  begin
    hits = 4'h0;
    unique case (mode)
      cafm_pkg::CAFM_MODE_32:
      begin
        hits[0] = agree(id[31:16], code[31:16], ign[31:16])
                & agree(id[15:0], code[15:0], ign[15:0]);
      end
      cafm_pkg::CAFM_MODE_16:
      begin
        // Upper two identifier bytes carry ID plus RTR/SRR and IDE
        hits[0] = agree(id[31:16], code[31:16], ign[31:16]);
        hits[1] = agree(id[31:16], code[15:0], ign[15:0]);
      end
      cafm_pkg::CAFM_MODE_8:
      begin
        for (int k = 0; k < 4; k++)
        begin
          hits[k] = agree({8'h00, id[31:24]}, {8'h00, code[31-8*k -: 8]},
                          {8'h00, ign[31-8*k -: 8]});
        end
      end
      cafm_pkg::CAFM_MODE_CLOSED:
      begin
        hits = 4'h0;
      end
    endcase
  end
endmodule : cafm_bank_match
`default_nettype wire

// ==== src/cafm_top.sv ====
// Acceptance filter, message buffers and APB register file of the CAN controller
// Notes on behaviour
// - A clear ignore bit demands the identifier bit equal the code bit for a match.
// - A set ignore bit removes that identifier bit from the comparison.
// - A filter matches only when every unignored identifier bit agrees with its code bit.
// - Second-bank ignore registers take writes only with init request and acknowledge set.
// - Each message buffer spans 16 bytes holding 13 bytes, same layout for receive and send.
// - Only the transmit buffer has a priority byte.
// - With time stamping on, a 16-bit timer value lands in the last two buffer bytes on success.
// - Time stamp bytes are written by hardware only; the CPU can only read them.
// - In 32-bit mode bank one forms filter 0 and bank two forms filter 1.
// - In 16-bit mode each bank gives two filters, bank one hits 0-1, bank two hits 2-3.
// - In 8-bit mode each bank gives four filters on the first byte, hits 0-3 and 4-7.
// - In closed mode nothing is stored and the receive full flag never sets.
//
// The APB interface to the registers was left to the implementer.
`include "cafm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cafm_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Received frame from the protocol engine, one-cycle strobe
  input wire logic RX_VALID,
  input wire logic [31:0] RX_ID,
  input wire logic [63:0] RX_DATA,
  input wire logic [3:0] RX_DLC,
  // Frame to send, held while TX_REQ is high
  output logic TX_REQ,
  output logic [31:0] TX_ID,
  output logic [63:0] TX_DATA,
  output logic [3:0] TX_DLC,
  output logic [7:0] TX_PRIO,
  input wire logic TX_DONE,
  // Interrupt
  output logic IRQ
);
  logic init_request;
  logic init_acknowledge;
  logic time_enable;
  cafm_pkg::cafm_mode_t mode;
  logic [2:0] status;
  logic [2:0] irq_mask;
  logic [2:0] hit_index;
  logic tx_req;
  logic [15:0] timer;
  logic [31:0] prdata;
  logic [7:0] acc_code [0:1][0:3];
  logic [7:0] ign_bits [0:1][0:3];
  logic [7:0] rx_foreground_buffer [0:`CAFM_BUF_BYTES-1];
  logic [7:0] tx_buf [0:`CAFM_BUF_BYTES-1];

  logic next_init_request;
  logic next_init_acknowledge;
  logic next_time_enable;
  cafm_pkg::cafm_mode_t next_mode;
  logic [2:0] next_status;
  logic [2:0] next_irq_mask;
  logic [2:0] next_hit_index;
  logic next_tx_req;
  logic [15:0] next_timer;
  logic [31:0] next_prdata;
  logic [7:0] next_acc_code [0:1][0:3];
  logic [7:0] next_ign_bits [0:1][0:3];
  logic [7:0] next_rx_buf [0:`CAFM_BUF_BYTES-1];
  logic [7:0] next_tx_buf [0:`CAFM_BUF_BYTES-1];

  logic [5:0] idx;
  logic addr_ok;
  logic wr;
  logic rd_setup;
  logic in_init;
  logic [3:0] hits1;
  logic [3:0] hits2;
  logic [7:0] hits;
  logic any_hit;
  logic [2:0] first_hit;
  logic accept;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  assign idx = PADDR[7:2];
  assign wbyte = PWDATA[7:0];
  assign in_init = init_request & init_acknowledge;

  function automatic logic mapped(input logic [5:0] i);
    mapped = (i <= `CAFM_IDX_TXGO) || (i >= `CAFM_IDX_CODE1);
  endfunction : mapped

  function automatic logic [31:0] bytes4(input logic [7:0] b0, input logic [7:0] b1,
                                         input logic [7:0] b2, input logic [7:0] b3);
    bytes4 = {b0, b1, b2, b3};
  endfunction : bytes4

  assign addr_ok = (PADDR[1:0] == 2'b00) && mapped(idx);
  assign wr = PSEL & PENABLE & PWRITE & addr_ok;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

  // Zero wait states; read data is captured in the setup cycle
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign PRDATA = prdata;

  cafm_bank_match u_bank1 (
    .code(bytes4(acc_code[0][0], acc_code[0][1], acc_code[0][2], acc_code[0][3])),
    .ign(bytes4(ign_bits[0][0], ign_bits[0][1], ign_bits[0][2], ign_bits[0][3])),
    .id(RX_ID),
    .mode(mode),
    .hits(hits1)
  );

  cafm_bank_match u_bank2 (
    .code(bytes4(acc_code[1][0], acc_code[1][1], acc_code[1][2], acc_code[1][3])),
    .ign(bytes4(ign_bits[1][0], ign_bits[1][1], ign_bits[1][2], ign_bits[1][3])),
    .id(RX_ID),
    .mode(mode),
    .hits(hits2)
  );

  // Place bank hits at their filter numbers
  always_comb
  begin
    hits = 8'h00;
    unique case (mode)
      cafm_pkg::CAFM_MODE_32: hits = {6'h00, hits2[0], hits1[0]};
      cafm_pkg::CAFM_MODE_16: hits = {4'h0, hits2[1:0], hits1[1:0]};
      cafm_pkg::CAFM_MODE_8: hits = {hits2, hits1};
      cafm_pkg::CAFM_MODE_CLOSED: hits = 8'h00;
    endcase
  end

  // Lowest numbered filter wins when several match
  always_comb
  begin
    first_hit = 3'h0;
    for (int k = 7; k >= 0; k--)
    begin
      if (hits[k])
      begin
        first_hit = k[2:0];
      end
    end
  end

  assign any_hit = |hits;
  // Reception is frozen during initialisation so filters can change safely
  assign accept = RX_VALID & any_hit & ~init_acknowledge;

  // Register read decode
  always_comb
  begin
    rd_byte = 8'h00;
    if (idx >= `CAFM_IDX_TXBUF)
    begin
      rd_byte = tx_buf[idx[3:0]];
    end
    else if (idx >= `CAFM_IDX_RXBUF)
    begin
      rd_byte = rx_foreground_buffer[idx[3:0]];
    end
    else if (idx >= `CAFM_IDX_CODE1)
    begin
      // Reads of code and ignore bytes are allowed at any time
      rd_byte = idx[2] ? ign_bits[idx[3]][idx[1:0]] : acc_code[idx[3]][idx[1:0]];
    end
    else
    begin
      case (idx)
        `CAFM_IDX_CTRL: rd_byte = {6'h00, time_enable, init_request};
        `CAFM_IDX_INITACK: rd_byte = {7'h00, init_acknowledge};
        `CAFM_IDX_MODE: rd_byte = {6'h00, mode};
        `CAFM_IDX_STAT: rd_byte = {5'h00, status};
        `CAFM_IDX_IRQMASK: rd_byte = {5'h00, irq_mask};
        `CAFM_IDX_HIT: rd_byte = {5'h00, hit_index};
        `CAFM_IDX_TXGO: rd_byte = {7'h00, tx_req};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Next state of the whole register file
  always_comb
  begin
    next_init_request = init_request;
    next_init_acknowledge = init_request;
    next_time_enable = time_enable;
    next_mode = mode;
    next_status = status;
    next_irq_mask = irq_mask;
    next_hit_index = hit_index;
    next_tx_req = tx_req;
    next_timer = timer + 16'h0001;
    // A refused read latches zero instead of whatever the index would decode to
    next_prdata = rd_setup ? {24'h000000, addr_ok ? rd_byte : 8'h00} : prdata;
    next_acc_code = acc_code;
    next_ign_bits = ign_bits;
    next_rx_buf = rx_foreground_buffer;
    next_tx_buf = tx_buf;

    if (wr)
    begin
      if (idx == `CAFM_IDX_CTRL)
      begin
        next_init_request = wbyte[`CAFM_CTRL_INIT_REQUEST];
        next_time_enable = wbyte[`CAFM_CTRL_TIME];
      end
      if (idx == `CAFM_IDX_MODE && in_init)
      begin
        next_mode = cafm_pkg::cafm_mode_t'(wbyte[1:0]);
      end
      if (idx == `CAFM_IDX_STAT)
      begin
        next_status = status & ~wbyte[2:0];
      end
      if (idx == `CAFM_IDX_IRQMASK)
      begin
        next_irq_mask = wbyte[2:0];
      end
      if (idx == `CAFM_IDX_TXGO && wbyte[`CAFM_TXGO_BIT])
      begin
        next_tx_req = 1'b1;
      end
      if (idx >= `CAFM_IDX_CODE1 && idx < `CAFM_IDX_RXBUF && in_init)
      begin
        if (idx[2])
        begin
          next_ign_bits[idx[3]][idx[1:0]] = wbyte;
        end
        else
        begin
          next_acc_code[idx[3]][idx[1:0]] = wbyte;
        end
      end
      // Send buffer is frozen while a request is pending; stamp bytes never take writes
      if (idx >= `CAFM_IDX_TXBUF && idx[3:0] < 4'(`CAFM_BUF_TS_HI) && !tx_req)
      begin
        next_tx_buf[idx[3:0]] = wbyte;
      end
    end

    if (TX_DONE && tx_req)
    begin
      next_tx_req = 1'b0;
      next_status[`CAFM_STAT_TXD] = 1'b1;
      if (time_enable)
      begin
        next_tx_buf[`CAFM_BUF_TS_HI] = timer[15:8];
        next_tx_buf[`CAFM_BUF_TS_LO] = timer[7:0];
      end
    end

    if (accept)
    begin
      // An unread buffer is kept; the new frame is dropped and flagged
      if (status[`CAFM_STAT_RXF])
      begin
        next_status[`CAFM_STAT_OVR] = 1'b1;
      end
      else
      begin
        for (int b = 0; b < 4; b++)
        begin
          next_rx_buf[b] = RX_ID[31-8*b -: 8];
        end
        for (int b = 0; b < 8; b++)
        begin
          next_rx_buf[4+b] = RX_DATA[63-8*b -: 8];
        end
        next_rx_buf[`CAFM_BUF_DLC] = {4'h0, RX_DLC};
        next_rx_buf[`CAFM_BUF_PRIO] = 8'h00;
        if (time_enable)
        begin
          next_rx_buf[`CAFM_BUF_TS_HI] = timer[15:8];
          next_rx_buf[`CAFM_BUF_TS_LO] = timer[7:0];
        end
        next_hit_index = first_hit;
        next_status[`CAFM_STAT_RXF] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      init_request <= 1'b0;
      init_acknowledge <= 1'b0;
      time_enable <= 1'b0;
      mode <= cafm_pkg::CAFM_MODE_32;
      status <= `CAFM_RST_STAT;
      irq_mask <= `CAFM_RST_STAT;
      hit_index <= `CAFM_RST_HIT;
      tx_req <= 1'b0;
      timer <= `CAFM_RST_TIMER;
      prdata <= 32'h00000000;
      for (int i = 0; i < 2; i++)
      begin
        for (int j = 0; j < 4; j++)
        begin
          acc_code[i][j] <= `CAFM_RST_BYTE;
          ign_bits[i][j] <= `CAFM_RST_BYTE;
        end
      end
      for (int i = 0; i < `CAFM_BUF_BYTES; i++)
      begin
        rx_foreground_buffer[i] <= `CAFM_RST_BYTE;
        tx_buf[i] <= `CAFM_RST_BYTE;
      end
    end
    else
    begin
      init_request <= next_init_request;
      init_acknowledge <= next_init_acknowledge;
      time_enable <= next_time_enable;
      mode <= next_mode;
      status <= next_status;
      irq_mask <= next_irq_mask;
      hit_index <= next_hit_index;
      tx_req <= next_tx_req;
      timer <= next_timer;
      prdata <= next_prdata;
      acc_code <= next_acc_code;
      ign_bits <= next_ign_bits;
      rx_foreground_buffer <= next_rx_buf;
      tx_buf <= next_tx_buf;
    end
  end

  // Send side sees the buffer straight from its flops
  assign TX_REQ = tx_req;
  assign TX_ID = bytes4(tx_buf[0], tx_buf[1], tx_buf[2], tx_buf[3]);
  assign TX_DATA = {bytes4(tx_buf[4], tx_buf[5], tx_buf[6], tx_buf[7]),
                    bytes4(tx_buf[8], tx_buf[9], tx_buf[10], tx_buf[11])};
  assign TX_DLC = tx_buf[`CAFM_BUF_DLC][3:0];
  assign TX_PRIO = tx_buf[`CAFM_BUF_PRIO];

  assign IRQ = |(status & irq_mask);
endmodule : cafm_top
`default_nettype wire

// ==== verification/cafm_assertions.sv ====
// Port assertions for the acceptance filter block
`timescale 1ns/1ps
`default_nettype none
module cafm_assertions #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Send side
  input wire logic TX_REQ,
  input wire logic [31:0] TX_ID,
  input wire logic [7:0] TX_PRIO,
  input wire logic TX_DONE
);
  logic go;
  logic hole;
  assign go = PSEL && PENABLE && PWRITE && PADDR[7:0] == 8'h18 && PWDATA[0];
  assign hole = PADDR[7:2] inside {[6'h07:6'h0F]};
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  sequence s_acc;
    PSEL && PENABLE;
  endsequence
  property p_ready;
    PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  property p_err_phase;
    PSLVERR |-> PSEL && PENABLE;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_unmapped;
    s_acc ##0 hole |-> PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not refused");
  property p_misalign;
    s_acc ##0 (PADDR[1:0] != 2'h0) |-> PSLVERR;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned not refused");
  property p_mapped;
    s_acc ##0 (PADDR[1:0] == 2'h0 && !hole) |-> !PSLVERR;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped refused");
  property p_go;
    go && !TX_REQ |=> TX_REQ;
  endproperty
  a_go: assert property (p_go) else $error("send not started");
  property p_rise;
    !TX_REQ && !go |=> !TX_REQ;
  endproperty
  a_rise: assert property (p_rise) else $error("send without request");
  property p_hold;
    TX_REQ && !TX_DONE |=> TX_REQ && $stable(TX_ID) && $stable(TX_PRIO);
  endproperty
  a_hold: assert property (p_hold) else $error("send frame moved");
  property p_done;
    TX_REQ && TX_DONE |=> !TX_REQ;
  endproperty
  a_done: assert property (p_done) else $error("send not ended");
endmodule : cafm_assertions
bind cafm_top cafm_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .TX_REQ(TX_REQ),
  .TX_ID(TX_ID),
  .TX_PRIO(TX_PRIO),
  .TX_DONE(TX_DONE)
);
`default_nettype wire

// ==== verification/cafm_engine_model.sv ====
// Behavioural protocol engine standing in for the other bus nodes
`timescale 1ns/1ps
`default_nettype none
module cafm_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Received frames
  output logic rx_valid,
  output logic [31:0] rx_id,
  output logic [63:0] rx_data,
  output logic [3:0] rx_dlc,
  // Send handshake
  input wire logic tx_req,
  output logic tx_done
);
  int lat = 0;
  int cnt = 0;
  initial
  begin
    rx_valid = 0;
    rx_id = 0;
    rx_data = 0;
    rx_dlc = 0;
    tx_done = 0;
  end
  // Lines show the inverse after a frame so stale data never looks valid
  task automatic send(input logic [31:0] id, input logic [63:0] d, input logic [3:0] n);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_data <= d;
    rx_dlc <= n;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_data <= ~d;
    rx_dlc <= ~n;
  endtask : send
  always @(posedge clk)
  begin
    tx_done <= 1'b0;
    if (rst)
      cnt <= 0;
    else if (tx_req && !tx_done)
    begin
      cnt <= (cnt >= lat) ? 0 : cnt + 1;
      tx_done <= (cnt >= lat);
    end
  end
endmodule : cafm_engine_model
`default_nettype wire

// ==== verification/can_acceptance_filter_msgbuf_bench.sv ====
// Self-checking bench for the acceptance filter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t %h %h", $time, (a), (b)); end end
module can_acceptance_filter_msgbuf_bench;
  logic clk, rst, psel, pen, pwr, prdy, perr, txreq, txdone, rxv, irq, er;
  logic [7:0] paddr, txprio;
  logic [31:0] pwdata, prdata, txid, rxid, rd;
  logic [63:0] txdata, rxdata;
  logic [3:0] txdlc, rxdlc;
  logic [31:0] cd [2];
  logic [31:0] ig [2];
  int failures, num_checks, cyc;
  cafm_top #(.ADDR_W(8)) DUT (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy),
    .PSLVERR(perr), .RX_VALID(rxv), .RX_ID(rxid), .RX_DATA(rxdata), .RX_DLC(rxdlc),
    .TX_REQ(txreq), .TX_ID(txid), .TX_DATA(txdata), .TX_DLC(txdlc), .TX_PRIO(txprio),
    .TX_DONE(txdone), .IRQ(irq));
  cafm_engine_model u_eng (.clk(clk), .rst(rst), .rx_valid(rxv), .rx_id(rxid),
    .rx_data(rxdata), .rx_dlc(rxdlc), .tx_req(txreq), .tx_done(txdone));
  task automatic finish_test;
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      finish_test();
    end
    rd = prdata;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  // Lowest numbered hitting filter, or -1
  function automatic int hit_ref(int m, logic [31:0] id);
    int per, w;
    longint msk, c, i, x;
    per = (m == 3) ? 0 : 1 << m;
    for (int f = 0; f < 2 * per; f++)
    begin
      w = 32 / per;
      msk = (64'h1 << w) - 1;
      c = (cd[f / per] >> (32 - w * (f % per + 1))) & msk;
      i = (ig[f / per] >> (32 - w * (f % per + 1))) & msk;
      x = (id >> (32 - w)) & msk;
      if (((c ^ x) & ~i & msk) == 0)
        return f;
    end
    return -1;
  endfunction : hit_ref
  always @(posedge clk)
    cyc <= cyc + 1;
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    logic [31:0] id;
    logic [63:0] dt;
    int h, s, e;
    int ts [2];
    int tc [2];
    rst = 1;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 0;
    pwdata = 0;
    void'($urandom(15));
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int k = 0; k < 4; k++)
    begin
      apb(1, 8'h70 + 8'(4 * k), 8'hA5);
      apb(0, 8'h70 + 8'(4 * k), 0);
      `CHK(rd[7:0], 8'h00)
    end
    apb(0, 8'h1C, 0);
    `CHK(er, 1'b1)
    apb(0, 8'h41, 0);
    `CHK(er, 1'b1)
    apb(1, 8'h10, 8'h01);
    // Closed mode first so the loop leaves 32-bit mode for the stamp test
    for (int m = 3; m >= 0; m--)
    begin
      apb(1, 8'h00, 8'h01);
      apb(1, 8'h08, 8'(m));
      for (int k = 0; k < 16; k++)
      begin
        s = $urandom;
        if (k[2])
          s = s & $urandom;
        apb(1, 8'h40 + 8'(4 * k), 8'(s));
        if (k[2])
          ig[k / 8][31 - 8 * (k % 4) -: 8] = 8'(s);
        else
          cd[k / 8][31 - 8 * (k % 4) -: 8] = 8'(s);
      end
      apb(0, 8'h7C, 0);
      `CHK(rd[7:0], ig[1][7:0])
      apb(1, 8'h00, 8'h00);
      apb(0, 8'h04, 0);
      `CHK(rd[7:0], 8'h00)
      for (int j = 0; j < 8; j++)
      begin
        id = $urandom;
        if (j[0])
          id = cd[j[1]] ^ (ig[j[1]] & $urandom);
        h = hit_ref(m, id);
        u_eng.send(id, {$urandom, $urandom}, 4'(j));
        apb(0, 8'h0C, 0);
        `CHK(rd[0], 1'(h >= 0))
        `CHK(irq, 1'(h >= 0))
        if (h >= 0)
        begin
          apb(0, 8'h14, 0);
          `CHK(rd[2:0], 3'(h))
          apb(0, 8'h80, 0);
          `CHK(rd[7:0], id[31:24])
          apb(0, 8'hB0, 0);
          `CHK(rd[3:0], 4'(j))
          apb(1, 8'h0C, 8'h01);
        end
      end
    end
    apb(1, 8'h00, 8'h02);
    for (int j = 0; j < 2; j++)
    begin
      u_eng.send(cd[0], 64'h0, 4'h1);
      tc[j] = cyc;
      apb(0, 8'hB8, 0);
      ts[j] = rd[7:0] << 8;
      apb(0, 8'hBC, 0);
      ts[j] = ts[j] | rd[7:0];
      apb(1, 8'h0C, 8'h01);
    end
    `CHK(16'(ts[1] - ts[0]), 16'(tc[1] - tc[0]))
    for (int j = 0; j < 2; j++)
    begin
      u_eng.lat = 6 * j;
      id = $urandom;
      dt = {$urandom, $urandom};
      s = $urandom;
      for (int k = 0; k < 4; k++)
        apb(1, 8'hC0 + 8'(4 * k), id[31 - 8 * k -: 8]);
      for (int k = 0; k < 8; k++)
        apb(1, 8'hD0 + 8'(4 * k), dt[63 - 8 * k -: 8]);
      apb(1, 8'hF0, s[15:8]);
      apb(1, 8'hF4, 8'(s));
      apb(1, 8'h18, 8'h01);
      #1;
      `CHK(txreq, 1'b1)
      `CHK(txid, id)
      `CHK(txdata, dt)
      `CHK(txdlc, s[11:8])
      `CHK(txprio, 8'(s))
      h = 0;
      while (txreq === 1'b1 && h < 50)
      begin
        @(negedge clk);
        h++;
      end
      `CHK(h < 50, 1'b1)
      if (h >= 50)
        finish_test();
      // Stamp is taken at the edge of the fall from the previous cycle's timer; the receive stamps give the timer offset
      e = cyc - 1 + ts[0] - tc[0];
      apb(0, 8'h0C, 0);
      `CHK(rd[1], 1'b1)
      apb(0, 8'hF8, 0);
      `CHK(rd[7:0], 8'(e >> 8))
      apb(0, 8'hFC, 0);
      `CHK(rd[7:0], 8'(e))
      s = rd[7:0];
      apb(1, 8'hFC, ~8'(s));
      apb(0, 8'hFC, 0);
      `CHK(rd[7:0], 8'(s))
      apb(0, 8'hB4, 0);
      `CHK(rd[7:0], 8'h00)
      apb(1, 8'h0C, 8'h02);
    end
    finish_test();
  end
endmodule : can_acceptance_filter_msgbuf_bench
`default_nettype wire
